// ---- csfb_pkg.sv ----
// shared constants for the controller status flag bank
package csfb_pkg;
  // axi4-lite register offsets
  localparam logic [7:0] CSFB_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CSFB_OFF_STATUS = 8'h04;
  localparam logic [7:0] CSFB_OFF_ALU    = 8'h08;
  localparam logic [7:0] CSFB_OFF_COMM   = 8'h0c;
  localparam logic [7:0] CSFB_OFF_CODE   = 8'h10;
  localparam logic [1:0] CSFB_RESP_OKAY   = 2'b00;
  localparam logic [1:0] CSFB_RESP_SLVERR = 2'b10;
  // control register bit positions
  localparam int CSFB_CTRL_CFGCHK = 0;
  // clock timing
  localparam int CSFB_CLK_MHZ       = 100;
  localparam int CSFB_MIN_HALF_S    = 30;
  localparam int CSFB_SEC_HALF_MS   = 500;
  localparam int CSFB_HMS_HALF_MS   = 50;
  localparam int CSFB_FMS_HALF_US   = 25000;
  localparam int CSFB_MS_CYC        = CSFB_CLK_MHZ * 1000;
  localparam int CSFB_FMS_HALF_CYC  = CSFB_FMS_HALF_US * CSFB_CLK_MHZ;
  localparam int CSFB_HMS_HALF_CYC  = CSFB_HMS_HALF_MS * CSFB_MS_CYC;
  localparam int CSFB_SEC_HALF_CYC  = CSFB_SEC_HALF_MS * CSFB_MS_CYC;
  // the minute half period in 25 ms ticks, so no count passes 32 bits
  localparam int CSFB_MIN_HALF_TICKS = CSFB_MIN_HALF_S * 40;
  localparam int CSFB_SEC_HALF_TICKS = CSFB_SEC_HALF_MS / 25;
  localparam int CSFB_HMS_HALF_TICKS = CSFB_HMS_HALF_MS / 25;
  // operating modes
  typedef enum logic [2:0] {
    CSFB_MODE_PROGRAM,
    CSFB_MODE_RUN,
    CSFB_MODE_TEST_PROGRAM,
    CSFB_MODE_TEST_RUN
  } csfb_mode_t;
  typedef enum logic [1:0] {
    CSFB_SW_STOP,
    CSFB_SW_TERM,
    CSFB_SW_RUN
  } csfb_switch_t;
  // comparison/arithmetic events
  typedef enum logic [2:0] {
    CSFB_OP_NONE,
    CSFB_OP_CMP,
    CSFB_OP_ADD16,
    CSFB_OP_SUB16,
    CSFB_OP_ADD32,
    CSFB_OP_SUB32,
    CSFB_OP_LOAD
  } csfb_op_t;
endpackage : csfb_pkg

// ---- csfb_tick_if.sv ----
// tick interface between wave generator and flag bank
`timescale 1ns/1ps
`default_nettype none
interface csfb_tick_if;
  logic minute_sq;
  logic second_sq;
  logic hundred_sq;
  logic fifty_sq;
  modport gen (output minute_sq, output second_sq, output hundred_sq, output fifty_sq);
  modport use_side (input minute_sq, input second_sq, input hundred_sq, input fifty_sq);
endinterface : csfb_tick_if
`default_nettype wire

// ---- csfb_wave_gen.sv ----
// free-running square-wave clock flags
`timescale 1ns/1ps
`default_nettype none
module csfb_wave_gen
  import csfb_pkg::*;
#(
  parameter int TICK_CYC = CSFB_FMS_HALF_CYC
) (
  // clock and reset
  input wire logic   core_clk,
  input wire logic   srst,
  // square waves
  csfb_tick_if.gen   waves
);
  logic [31:0] pre_q;
  logic        tick;
  logic [11:0] min_q;
  logic [4:0]  sec_q;
  logic [1:0]  hms_q;
  logic        min_sq_q, sec_sq_q, hms_sq_q, fms_sq_q;

  // 25 ms enable pulse from the core clock
  always_ff @(posedge core_clk) begin
    if (srst || tick) begin
      pre_q <= 32'h0;
    end else begin
      pre_q <= pre_q + 32'h1;
    end
  end
  assign tick = (pre_q == 32'(TICK_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fms_sq_q <= 1'b1;
    end else if (tick) begin
      fms_sq_q <= ~fms_sq_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hms_q    <= 2'h0;
      hms_sq_q <= 1'b1;
    end else if (tick) begin
      if (hms_q == 2'(CSFB_HMS_HALF_TICKS - 1)) begin
        hms_q    <= 2'h0;
        hms_sq_q <= ~hms_sq_q;
      end else begin
        hms_q <= hms_q + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sec_q    <= 5'h0;
      sec_sq_q <= 1'b1;
    end else if (tick) begin
      if (sec_q == 5'(CSFB_SEC_HALF_TICKS - 1)) begin
        sec_q    <= 5'h0;
        sec_sq_q <= ~sec_sq_q;
      end else begin
        sec_q <= sec_q + 5'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      min_q    <= 12'h0;
      min_sq_q <= 1'b1;
    end else if (tick) begin
      if (min_q == 12'(CSFB_MIN_HALF_TICKS - 1)) begin
        min_q    <= 12'h0;
        min_sq_q <= ~min_sq_q;
      end else begin
        min_q <= min_q + 12'h1;
      end
    end
  end

  assign waves.minute_sq  = min_sq_q;
  assign waves.second_sq  = sec_sq_q;
  assign waves.hundred_sq = hms_sq_q;
  assign waves.fifty_sq   = fms_sq_q;

  // fifty ms wave only flips on a tick
  a_fifty_ms_flip: assert property (@(posedge core_clk) disable iff (srst)
    $changed(fms_sq_q) |-> $past(tick)) else $error("fifty ms wave moved off tick");
  // hundred ms wave flips every second tick
  a_hundred_ms_flip: assert property (@(posedge core_clk) disable iff (srst)
    $changed(hms_sq_q) |-> $past(tick) && $past(hms_q) == 2'h1)
    else $error("hundred ms wave flipped early");
endmodule : csfb_wave_gen
`default_nettype wire

// ---- csfb_flag_bank.sv ----
// controller status flag bank with axi4-lite access
// Operation
// - first-scan flag high only during first scan after reset or program-to-run.
// - one flag always set, another always clear.
// - minute wave, thirty seconds high, thirty low.
// - second wave, half second high, half second low.
// - hundred ms wave, fifty ms high, fifty low.
// - fifty ms wave, twenty-five ms high, twenty-five low.
// - alternate-scan flag toggles every program scan.
// - forced-run flag follows mode switch in run position.
// - in terminal position exactly one mode flag set per operating mode.
// - break flag one set on break, clear in any other mode.
// - break flag two set on break, held until mode becomes run.
// - keyswitch-stop flag follows stop position; stop instruction sets its own flag.
// - interrupts-enabled flag set by the interrupt-enable instruction.
// - critical fault flag and warning flag on their fault classes.
// - io configuration fault only reported while power-up check enabled.
// - syntax fault sets flag and stores the exact error code word.
// - compare sets exactly one of less, equal, greater.
// - half borrow/carry for 16-bit, full borrow/carry for 32-bit.
// - negative flag on negative accumulator; overflow on wrong signed result sign.
// - decimal data fault when an operand digit is not decimal.
// - four flags mirror counter module inputs zero to three.
// - per-slot busy flags; program must test before network read or write.
`timescale 1ns/1ps
`default_nettype none
module csfb_flag_bank
  import csfb_pkg::*;
#(
  parameter int SLOTS    = 8,
  parameter int TICK_CYC = CSFB_FMS_HALF_CYC
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // scan and mode events from the cpu core
  input  wire logic               scan_start,
  input  wire logic [2:0]         op_mode,
  input  wire logic               break_exec,
  input  wire logic               stop_exec,
  input  wire logic               interrupt_enable_instruction,
  // fault events
  input  wire logic               critical_fault_evt,
  input  wire logic               warning_evt,
  input  wire logic               io_config_mismatch_evt,
  input  wire logic               syntax_fault_evt,
  input  wire logic [15:0]        syntax_fault_code,
  // accumulator results
  input  wire logic [2:0]         alu_op,
  input  wire logic [31:0]        acc_value,
  input  wire logic [31:0]        operand_value,
  input  wire logic               bcd_expected,
  // pins from outside the clock domain
  input  wire logic [1:0]         mode_switch,
  input  wire logic [3:0]         counter_inputs,
  input  wire logic [SLOTS-1:0]   slot_busy,
  input  wire logic [SLOTS-1:0]   slot_comm_fault,
  // flag outputs
  output logic                    first_scan_flag,
  output logic                    constant_on_flag,
  output logic                    constant_off_flag,
  output logic                    minute_square_wave,
  output logic                    second_square_wave,
  output logic                    hundred_ms_square_wave,
  output logic                    fifty_ms_square_wave,
  output logic                    alternate_scan_flag
);
  csfb_tick_if waves ();
  csfb_mode_t  mode;
  logic [1:0]  sw_s1_q, sw_s2_q;
  logic [3:0]  cin_s1_q, cin_s2_q;
  logic [SLOTS-1:0] busy_s1_q, busy_s2_q, cf_s1_q, cf_s2_q;
  logic        first_q, alt_q, was_prog_q;
  logic        brk1_q, brk2_q, stop_q, ie_q;
  logic        crit_q, warn_q, iocfg_q, syn_q, cfgchk_q;
  logic [15:0] code_q;
  logic        lt_q, eq_q, gt_q, hb_q, fb_q, hc_q, fc_q, neg_q, ov_q, bcd_q;
  logic [32:0] sum33;
  logic [16:0] sum17;
  logic        bad_digit, term_pos;
  logic        aw_done_q, w_done_q;
  logic [31:0] wdata_q;
  logic [7:0]  awaddr_q;
  logic [31:0] rd_word;
  logic [31:0] status_word, alu_word;

  assign mode = csfb_mode_t'(op_mode);

  csfb_wave_gen #(.TICK_CYC(TICK_CYC)) u_wave (
    .core_clk (core_clk),
    .srst     (srst),
    .waves    (waves)
  );

  // two-stage synchronisers for pin inputs
  always_ff @(posedge core_clk) begin
    sw_s1_q   <= mode_switch;
    sw_s2_q   <= sw_s1_q;
    cin_s1_q  <= counter_inputs;
    cin_s2_q  <= cin_s1_q;
    busy_s1_q <= slot_busy;
    busy_s2_q <= busy_s1_q;
    cf_s1_q   <= slot_comm_fault;
    cf_s2_q   <= cf_s1_q;
  end

  // first scan tracking, rearmed by reset or program-to-run
  always_ff @(posedge core_clk) begin
    if (srst) begin
      first_q    <= 1'b0;
      was_prog_q <= 1'b1;
    end else if (scan_start) begin
      first_q    <= was_prog_q;
      was_prog_q <= 1'b0;
    end else if (mode == CSFB_MODE_PROGRAM) begin
      was_prog_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      alt_q <= 1'b0;
    end else if (scan_start) begin
      alt_q <= ~alt_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      brk1_q <= 1'b0;
      brk2_q <= 1'b0;
    end else begin
      brk1_q <= break_exec | (brk1_q & (op_mode > 3'h3));
      // set wins over clear
      brk2_q <= break_exec | (brk2_q & (mode != CSFB_MODE_RUN));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stop_q <= 1'b0;
      ie_q   <= 1'b0;
    end else begin
      stop_q <= stop_q | stop_exec;
      ie_q   <= ie_q | interrupt_enable_instruction;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      crit_q  <= 1'b0;
      warn_q  <= 1'b0;
      iocfg_q <= 1'b0;
      syn_q   <= 1'b0;
      code_q  <= 16'h0;
    end else begin
      crit_q  <= crit_q | critical_fault_evt;
      warn_q  <= warn_q | warning_evt;
      // mismatch is ignored unless the check is enabled
      iocfg_q <= cfgchk_q & (iocfg_q | io_config_mismatch_evt);
      syn_q   <= syn_q | syntax_fault_evt;
      if (syntax_fault_evt) begin
        code_q <= syntax_fault_code;
      end
    end
  end

  // arithmetic terms for the accumulator flags
  assign sum33 = (alu_op == CSFB_OP_SUB32) ? ({1'b0, acc_value} - {1'b0, operand_value})
                                           : ({1'b0, acc_value} + {1'b0, operand_value});
  assign sum17 = (alu_op == CSFB_OP_SUB16) ? ({1'b0, acc_value[15:0]} - {1'b0, operand_value[15:0]})
                                           : ({1'b0, acc_value[15:0]} + {1'b0, operand_value[15:0]});
  // any nibble above nine is not decimal
  always_comb begin
    bad_digit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (operand_value[i*4 +: 4] > 4'h9) begin
        bad_digit = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      {lt_q, eq_q, gt_q, hb_q, fb_q, hc_q, fc_q, neg_q, ov_q, bcd_q} <= 10'h0;
    end else begin
      case (csfb_op_t'(alu_op))
        CSFB_OP_CMP: begin
          lt_q <= acc_value < operand_value;
          eq_q <= acc_value == operand_value;
          gt_q <= acc_value > operand_value;
        end
        CSFB_OP_ADD16: begin
          hc_q  <= sum17[16];
          neg_q <= sum17[15];
          ov_q  <= (acc_value[15] == operand_value[15]) && (sum17[15] != acc_value[15]);
        end
        CSFB_OP_SUB16: begin
          hb_q  <= sum17[16];
          neg_q <= sum17[15];
          ov_q  <= (acc_value[15] != operand_value[15]) && (sum17[15] != acc_value[15]);
        end
        CSFB_OP_ADD32: begin
          fc_q  <= sum33[32];
          neg_q <= sum33[31];
          ov_q  <= (acc_value[31] == operand_value[31]) && (sum33[31] != acc_value[31]);
        end
        CSFB_OP_SUB32: begin
          fb_q  <= sum33[32];
          neg_q <= sum33[31];
          ov_q  <= (acc_value[31] != operand_value[31]) && (sum33[31] != acc_value[31]);
        end
        CSFB_OP_LOAD: begin
          neg_q <= operand_value[31];
          bcd_q <= bcd_expected & bad_digit;
        end
        default: begin
        end
      endcase
    end
  end

  assign first_scan_flag        = first_q;
  assign constant_on_flag       = 1'b1;
  assign constant_off_flag      = 1'b0;
  assign minute_square_wave     = waves.minute_sq;
  assign second_square_wave     = waves.second_sq;
  assign hundred_ms_square_wave = waves.hundred_sq;
  assign fifty_ms_square_wave   = waves.fifty_sq;
  assign alternate_scan_flag    = alt_q;

  // status word from mode, switch and counter mirrors
  assign term_pos    = (sw_s2_q == CSFB_SW_TERM);
  assign status_word = {4'h0, cin_s2_q, 2'h0, syn_q, iocfg_q, warn_q, crit_q, ie_q, stop_q,
                        (sw_s2_q == CSFB_SW_STOP), brk2_q, brk1_q,
                        term_pos && (mode == CSFB_MODE_PROGRAM),
                        term_pos && (mode == CSFB_MODE_TEST_PROGRAM),
                        term_pos && (mode == CSFB_MODE_TEST_RUN),
                        term_pos && (mode == CSFB_MODE_RUN),
                        (sw_s2_q == CSFB_SW_RUN), alt_q,
                        waves.fifty_sq, waves.hundred_sq, waves.second_sq, waves.minute_sq,
                        1'b0, 1'b1, first_q};
  assign alu_word = {22'h0, bcd_q, ov_q, neg_q, fc_q, hc_q, fb_q, hb_q, gt_q, eq_q, lt_q};

  // axi4-lite write: address and data accepted in any order
  assign s_axi_awready = !aw_done_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_done_q && !s_axi_bvalid;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      aw_done_q    <= 1'b0;
      w_done_q     <= 1'b0;
      awaddr_q     <= 8'h0;
      wdata_q      <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CSFB_RESP_OKAY;
      cfgchk_q     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end
      if (aw_done_q && w_done_q) begin
        aw_done_q    <= 1'b0;
        w_done_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({awaddr_q[7:2], 2'b00} == CSFB_OFF_CTRL) begin
          s_axi_bresp <= CSFB_RESP_OKAY;
          cfgchk_q    <= wdata_q[CSFB_CTRL_CFGCHK];
        end else begin
          s_axi_bresp <= CSFB_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode
  always_comb begin
    case ({s_axi_araddr[7:2], 2'b00})
      CSFB_OFF_CTRL:   rd_word = {31'h0, cfgchk_q};
      CSFB_OFF_STATUS: rd_word = status_word;
      CSFB_OFF_ALU:    rd_word = alu_word;
      CSFB_OFF_COMM:   rd_word = {16'h0, 8'(cf_s2_q), 8'(busy_s2_q)};
      CSFB_OFF_CODE:   rd_word = {16'h0, code_q};
      default:         rd_word = 32'h0;
    endcase
  end

  // axi4-lite read, one outstanding
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= CSFB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= ({s_axi_araddr[7:2], 2'b00} > CSFB_OFF_CODE) ? CSFB_RESP_SLVERR
                                                                   : CSFB_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // first scan only follows a reset or a program stay
  a_first_scan_src: assert property (@(posedge core_clk) disable iff (srst)
    $rose(first_q) |-> $past(scan_start) && $past(was_prog_q))
    else $error("first scan flag without restart");
  // alternate flag toggles exactly with scans
  a_alt_toggle: assert property (@(posedge core_clk) disable iff (srst)
    $past(scan_start) |-> alt_q != $past(alt_q)) else $error("alternate flag stuck");
  a_scan_stable: assert property (@(posedge core_clk) disable iff (srst)
    !$past(scan_start) |-> $stable(alt_q) && $stable(first_q))
    else $error("scan flag moved mid scan");
  a_break_two_hold: assert property (@(posedge core_clk) disable iff (srst)
    brk2_q && mode != CSFB_MODE_RUN |=> brk2_q) else $error("break two dropped early");
  // config fault never set while check disabled
  a_iocfg_gate: assert property (@(posedge core_clk) disable iff (srst)
    !cfgchk_q |=> !iocfg_q) else $error("io config fault while disabled");
  a_syntax_code: assert property (@(posedge core_clk) disable iff (srst)
    syntax_fault_evt |=> syn_q && code_q == $past(syntax_fault_code))
    else $error("syntax code not captured");
  a_cmp_onehot: assert property (@(posedge core_clk) disable iff (srst)
    alu_op == CSFB_OP_CMP |=> $onehot({lt_q, eq_q, gt_q})) else $error("compare not one-hot");
  // terminal mode flags one-hot in terminal position
  a_term_onehot: assert property (@(posedge core_clk) disable iff (srst)
    sw_s2_q == CSFB_SW_TERM && op_mode < 3'h4 |-> $onehot(status_word[12:9]))
    else $error("terminal mode flags not one-hot");
endmodule : csfb_flag_bank
`default_nettype wire

// ---- csfb_tb.sv ----
// self-checking bench for the controller status flag bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import csfb_pkg::*;
;
  // short tick so the minute wave fits the run
  localparam int TK = 4;
  typedef struct {
    logic [2:0] op; logic [31:0] a; logic [31:0] b; logic bcd; logic [31:0] m; logic [31:0] e;
  } csfb_row_t;
  logic        core_clk, srst, v;
  logic [7:0]  awaddr, araddr, evt, busy, cfault;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, acc, opd, d;
  logic [1:0]  bresp, rresp, msw, r;
  logic [2:0]  mode, aop;
  logic        bcd, fs, con, coff, alt, wm, ws, wh, wf;
  logic [15:0] code;
  logic [3:0]  cnt_in;
  wire  [3:0]  w = {wm, ws, wh, wf};
  int          fails, compares;
  int          mb [4] = '{12, 9, 11, 10};
  csfb_row_t   rows [12];

  csfb_flag_bank #(.SLOTS(8), .TICK_CYC(TK)) dut (
    .core_clk(core_clk), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scan_start(evt[0]), .op_mode(mode), .break_exec(evt[1]), .stop_exec(evt[2]),
    .interrupt_enable_instruction(evt[3]), .critical_fault_evt(evt[4]),
    .warning_evt(evt[5]), .io_config_mismatch_evt(evt[6]), .syntax_fault_evt(evt[7]),
    .syntax_fault_code(code), .alu_op(aop), .acc_value(acc), .operand_value(opd),
    .bcd_expected(bcd), .mode_switch(msw), .counter_inputs(cnt_in), .slot_busy(busy),
    .slot_comm_fault(cfault), .first_scan_flag(fs), .constant_on_flag(con),
    .constant_off_flag(coff), .minute_square_wave(wm), .second_square_wave(ws),
    .hundred_ms_square_wave(wh), .fifty_ms_square_wave(wf), .alternate_scan_flag(alt));

  // verdict and end of run, also reached from any timeout
  task automatic results();
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk

  // ready is looked at mid-cycle, so the handshake edge is the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
    int n;
    logic ta, tw, b;
    @(posedge core_clk);
    awaddr <= a; wdata <= dv; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    b = 1'b0;
    for (n = 0; n < 200 && !b; n++) begin
      @(negedge core_clk);
      ta = awvalid & awready; tw = wvalid & wready; b = bvalid & bready;
      if (b) chk(bresp, er);
      @(posedge core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) begin fails++; results(); end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int n;
    logic t, g;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    g = 1'b0;
    for (n = 0; n < 200 && !g; n++) begin
      @(negedge core_clk);
      t = arvalid & arready; g = rvalid & rready; dv = rdata; rv = rresp;
      @(posedge core_clk);
      if (t) arvalid <= 1'b0;
      if (g) rready <= 1'b0;
    end
    if (!g) begin fails++; results(); end
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] dv;
    logic [1:0]  rv;
    rd(a, dv, rv);
    chk(rv, CSFB_RESP_OKAY);
    chk(dv & m, e);
  endtask : rchk

  // one-cycle event pulse, then time for the pin syncs to settle; ends off the edge
  task automatic ev(input int k);
    @(posedge core_clk);
    evt[k] <= 1'b1;
    @(posedge core_clk);
    evt <= 8'h00;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask : ev

  // half period of one wave, counted between two changes
  task automatic half(input int i, input int n);
    int c;
    logic s;
    @(negedge core_clk);
    s = w[i];
    for (c = 0; w[i] === s && c < 10000; c++) @(negedge core_clk);
    if (c == 10000) begin fails++; results(); end
    s = w[i];
    for (c = 0; w[i] === s && c < 10000; c++) @(negedge core_clk);
    if (c == 10000) begin fails++; results(); end
    chk(c, n);
  endtask : half

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // main sequence: reset, row table, then hand-written cases
  initial begin
    srst = 1'b1; awaddr = 8'h00; araddr = 8'h00; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; evt = 8'h00;
    mode = CSFB_MODE_RUN; aop = CSFB_OP_NONE; acc = 32'h0; opd = 32'h0; bcd = 1'b0;
    code = 16'h0; msw = CSFB_SW_STOP; cnt_in = 4'h0; busy = 8'h00; cfault = 8'h00;
    fails = 0; compares = 0;
    rows[0]  = '{CSFB_OP_CMP, 32'h5, 32'h9, 1'b0, 32'h7, 32'h1};
    rows[1]  = '{CSFB_OP_CMP, 32'h9, 32'h9, 1'b0, 32'h7, 32'h2};
    rows[2]  = '{CSFB_OP_CMP, 32'ha, 32'h9, 1'b0, 32'h7, 32'h4};
    rows[3]  = '{CSFB_OP_ADD16, 32'hffff, 32'h1, 1'b0, 32'h20, 32'h20};
    rows[4]  = '{CSFB_OP_ADD16, 32'h1, 32'h1, 1'b0, 32'h20, 32'h0};
    rows[5]  = '{CSFB_OP_SUB16, 32'h1, 32'h2, 1'b0, 32'h8, 32'h8};
    rows[6]  = '{CSFB_OP_SUB32, 32'h1, 32'h2, 1'b0, 32'h10, 32'h10};
    rows[7]  = '{CSFB_OP_ADD32, 32'hffffffff, 32'h1, 1'b0, 32'h40, 32'h40};
    rows[8]  = '{CSFB_OP_ADD32, 32'h7fffffff, 32'h1, 1'b0, 32'h1c0, 32'h180};
    rows[9]  = '{CSFB_OP_LOAD, 32'h0, 32'h80000000, 1'b0, 32'h80, 32'h80};
    rows[10] = '{CSFB_OP_LOAD, 32'h5, 32'h0, 1'b0, 32'h80, 32'h0};
    rows[11] = '{CSFB_OP_LOAD, 32'h0, 32'h1a, 1'b1, 32'h200, 32'h200};
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(negedge core_clk);
    chk({fs, con, coff, w}, 7'h2f);
    rchk(CSFB_OFF_CTRL, 32'hffffffff, 32'h0);
    rchk(CSFB_OFF_STATUS, 32'h7, 32'h2);
    half(0, TK);
    half(1, TK * CSFB_HMS_HALF_TICKS);
    half(2, TK * CSFB_SEC_HALF_TICKS);
    half(3, TK * CSFB_MIN_HALF_TICKS);
    foreach (rows[i]) begin
      @(posedge core_clk);
      aop <= rows[i].op; acc <= rows[i].a; opd <= rows[i].b; bcd <= rows[i].bcd;
      @(posedge core_clk);
      aop <= CSFB_OP_NONE;
      rchk(CSFB_OFF_ALU, rows[i].m, rows[i].e);
    end
    ev(0);
    repeat (10) @(negedge core_clk);
    chk(fs, 1'b1);
    v = alt;
    ev(0);
    chk(fs, 1'b0);
    chk(alt, !v);
    @(posedge core_clk) mode <= CSFB_MODE_PROGRAM;
    ev(0);
    @(posedge core_clk) mode <= CSFB_MODE_RUN;
    ev(0);
    chk(fs, 1'b1);
    @(posedge core_clk) msw <= CSFB_SW_RUN;
    ev(0);
    rchk(CSFB_OFF_STATUS, 32'h100, 32'h100);
    @(posedge core_clk) msw <= CSFB_SW_TERM;
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk) mode <= m[2:0];
      ev(0);
      rchk(CSFB_OFF_STATUS, 32'h1f00, 32'h1 << mb[m]);
    end
    @(posedge core_clk) msw <= CSFB_SW_STOP;
    ev(0);
    rchk(CSFB_OFF_STATUS, 32'h8000, 32'h8000);
    @(posedge core_clk) mode <= 3'h4;
    ev(1);
    rchk(CSFB_OFF_STATUS, 32'h6000, 32'h6000);
    @(posedge core_clk) mode <= CSFB_MODE_PROGRAM;
    ev(0);
    rchk(CSFB_OFF_STATUS, 32'h6000, 32'h4000);
    @(posedge core_clk) mode <= CSFB_MODE_RUN;
    ev(0);
    rchk(CSFB_OFF_STATUS, 32'h6000, 32'h0);
    ev(2);
    ev(3);
    ev(4);
    ev(5);
    rchk(CSFB_OFF_STATUS, 32'hf0000, 32'hf0000);
    // mismatch ignored until the check is enabled
    ev(6);
    rchk(CSFB_OFF_STATUS, 32'h100000, 32'h0);
    wr(CSFB_OFF_CTRL, 32'h1, CSFB_RESP_OKAY);
    rchk(CSFB_OFF_CTRL, 32'h1, 32'h1);
    ev(6);
    rchk(CSFB_OFF_STATUS, 32'h100000, 32'h100000);
    @(posedge core_clk) code <= 16'h1234;
    ev(7);
    rchk(CSFB_OFF_STATUS, 32'h200000, 32'h200000);
    rchk(CSFB_OFF_CODE, 32'hffff, 32'h1234);
    @(posedge core_clk);
    cnt_in <= 4'ha; busy <= 8'h81; cfault <= 8'h42;
    repeat (6) @(posedge core_clk);
    rchk(CSFB_OFF_STATUS, 32'hf000000, 32'ha000000);
    rchk(CSFB_OFF_COMM, 32'hffff, 32'h4281);
    // read-only and unmapped places are refused
    wr(CSFB_OFF_STATUS, 32'hffffffff, CSFB_RESP_SLVERR);
    rd(8'h14, d, r);
    chk(d, 32'h0);
    chk(r, CSFB_RESP_SLVERR);
    // second reset in mid-run clears the sticky faults
    @(posedge core_clk) srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rchk(CSFB_OFF_CTRL, 32'hffffffff, 32'h0);
    rchk(CSFB_OFF_STATUS, 32'h3f0007, 32'h2);
    results();
  end
endmodule : tb
`default_nettype wire
